// ### design/phy_codec_pkg.sv
// Shared types and constants for the transceiver symbol codec
package phy_codec_pkg;

    localparam logic [4:0] SYM_IDLE = 5'h1F;
    localparam logic [4:0] SYM_J    = 5'h18;
    localparam logic [4:0] SYM_K    = 5'h11;
    localparam logic [4:0] SYM_T    = 5'h0D;
    localparam logic [4:0] SYM_R    = 5'h07;
    localparam logic [4:0] SYM_H    = 5'h04;

    localparam logic [3:0] NIB_PREAMBLE = 4'h5;
    localparam logic [3:0] NIB_ZERO     = 4'h0;

    // Cycles of silence on the receive line; unused, the link is judged lost once sig_100 and sig_10 are both low
    localparam int         LINK_IDLE_CYC = 16;
    localparam logic [4:0] LINK_IDLE_MAX = 5'(LINK_IDLE_CYC - 1);

    // Ability bit positions, listed in priority order from highest
    localparam int ABIL_W      = 4;
    localparam int ABIL_100FD  = 3;
    localparam int ABIL_100HD  = 2;
    localparam int ABIL_10FD   = 1;
    localparam int ABIL_10HD   = 0;

    localparam logic [3:0] ABIL_NONE = 4'h0;

    typedef enum logic [1:0] {
        RX_HUNT   = 2'b00,
        RX_KWAIT  = 2'b01,
        RX_FRAME  = 2'b10,
        RX_RWAIT  = 2'b11
    } rx_state_t;

    typedef enum logic [1:0] {
        AN_IDLE   = 2'b00,
        AN_ACKW   = 2'b01,
        AN_UP     = 2'b10
    } an_state_t;

    // Nibble stream toward the reconciliation layer
    typedef struct packed {
        logic       valid;
        logic       err;
        logic [3:0] data;
    } nib_t;

    // Result of the five-bit lookup
    typedef struct packed {
        logic       is_data;
        logic       invalid;
        logic [3:0] nib;
    } dec_t;

endpackage

// ### design/sym_lut.sv
// Registered five-bit to four-bit code-group lookup
`timescale 1ns/1ps
`default_nettype none
module sym_lut
    import phy_codec_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [4:0] sym,
    output var  dec_t       dec_ff
);
    dec_t nxt_dec;

    always_comb begin
        nxt_dec = '{is_data: 1'b1, invalid: 1'b0, nib: 4'h0};
        unique case (sym)
            5'h1E: nxt_dec.nib = 4'h0;
            5'h09: nxt_dec.nib = 4'h1;
            5'h14: nxt_dec.nib = 4'h2;
            5'h15: nxt_dec.nib = 4'h3;
            5'h0A: nxt_dec.nib = 4'h4;
            5'h0B: nxt_dec.nib = 4'h5;
            5'h0E: nxt_dec.nib = 4'h6;
            5'h0F: nxt_dec.nib = 4'h7;
            5'h12: nxt_dec.nib = 4'h8;
            5'h13: nxt_dec.nib = 4'h9;
            5'h16: nxt_dec.nib = 4'hA;
            5'h17: nxt_dec.nib = 4'hB;
            5'h1A: nxt_dec.nib = 4'hC;
            5'h1B: nxt_dec.nib = 4'hD;
            5'h1C: nxt_dec.nib = 4'hE;
            5'h1D: nxt_dec.nib = 4'hF;
            SYM_IDLE, SYM_J, SYM_K, SYM_T, SYM_R, SYM_H: begin
                nxt_dec.is_data = 1'b0;
                nxt_dec.nib     = (sym == SYM_J || sym == SYM_K) ? NIB_PREAMBLE : 4'h0;
            end
            default: begin
                nxt_dec.is_data = 1'b0;
                nxt_dec.invalid = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dec_ff <= '0;
        end else begin
            dec_ff <= nxt_dec;
        end
    end
endmodule
`default_nettype wire

// ### design/phy_symbol_decode_crs_col.sv
// Transceiver digital core: 4B/5B receive, 10M Manchester, CRS/COL, link resolution
//
// Functional notes
// - Each aligned five-bit code group is turned into a nibble by a fixed table.
// - The J/K start pair is removed and two preamble nibbles are sent in its place.
// - The T/R end pair is removed and never reaches the nibble side.
// - Alignment starts only after a J/K pair and then stays on that boundary.
// - In 10 Mb/s mode transmit nibbles are serialised and Manchester encoded.
// - In 10 Mb/s mode received Manchester bits are decoded and regrouped into nibbles.
// - Half duplex flags a collision whenever transmit and receive are both active.
// - Full duplex never flags a collision.
// - Half duplex raises carrier sense while transmitting or receiving.
// - Full duplex raises carrier sense only while receiving.
// - Both ends advertise abilities, acknowledge the partner and drop unshared modes.
// - Among shared modes exactly one is chosen by fixed priority.
// - A non-negotiating partner is matched by the kind of signal it sends.
`timescale 1ns/1ps
`default_nettype none
module phy_symbol_decode_crs_col
    import phy_codec_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       rx_bit,
    input  wire logic       rx_bit_en,
    input  wire logic       tx_en,
    input  wire logic [3:0] tx_nib,
    input  wire logic       speed_100,
    input  wire logic       an_enable,
    input  wire logic [3:0] local_abil,
    input  wire logic [3:0] partner_abil,
    input  wire logic       partner_page,
    input  wire logic       partner_ack,
    input  wire logic       sig_100,
    input  wire logic       sig_10,
    output var  nib_t       rx_nib_ff,
    output var  logic       crs_ff,
    output var  logic       col_ff,
    output var  logic       man_tx_ff,
    output var  logic       tx_bit_req_ff,
    output var  logic       an_ack_ff,
    output var  logic [3:0] adv_abil_ff,
    output var  logic       link_up_ff,
    output var  logic [3:0] link_mode_ff
);
    // Line-side pins other than partner_abil pass two flops before any logic looks at them
    logic [1:0] s1_ff, s2_ff;
    logic [3:0] p1_ff, p2_ff;
    logic       rxb, rxe, pg, pa, s100, s10;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_ff <= '0;
            s2_ff <= '0;
            p1_ff <= '0;
            p2_ff <= '0;
        end else begin
            s1_ff <= {rx_bit, rx_bit_en};
            s2_ff <= s1_ff;
            p1_ff <= {partner_page, partner_ack, sig_100, sig_10};
            p2_ff <= p1_ff;
        end
    end
    assign {rxb, rxe}         = s2_ff;
    assign {pg, pa, s100, s10} = p2_ff;

    // 100M receive: shift, hunt for J/K, then hold the 5-bit boundary
    logic [9:0] sh_ff, nxt_sh;
    logic [2:0] cnt_ff, nxt_cnt;
    rx_state_t  st_ff, nxt_st;
    logic       grp_ff, nxt_grp;
    logic       pre_ff, nxt_pre;
    logic [4:0] grp_sym_ff, nxt_grp_sym;
    logic       rx_act_ff, nxt_rx_act;
    logic       pend_ff, nxt_pend;
    dec_t       dec;
    logic [4:0] lut_in;

    assign lut_in = grp_sym_ff;

    sym_lut sym_lut_inst (
        .clk    (clk),
        .rst_b  (rst_b),
        .sym    (lut_in),
        .dec_ff (dec)
    );

    always_comb begin
        nxt_sh      = sh_ff;
        nxt_cnt     = cnt_ff;
        nxt_st      = st_ff;
        nxt_grp     = 1'b0;
        nxt_pre     = 1'b0;
        nxt_grp_sym = grp_sym_ff;
        nxt_rx_act  = rx_act_ff;
        if (speed_100 && rxe) begin
            nxt_sh = {sh_ff[8:0], rxb};
            unique case (st_ff)
                RX_HUNT: begin
                    if ({sh_ff[8:0], rxb} == {SYM_J, SYM_K}) begin
                        nxt_st     = RX_FRAME;
                        nxt_cnt    = 3'd0;
                        nxt_pre    = 1'b1;
                        nxt_rx_act = 1'b1;
                    end
                end
                RX_FRAME, RX_KWAIT, RX_RWAIT: begin
                    nxt_cnt = cnt_ff + 3'd1;
                    if (cnt_ff == 3'd4) begin
                        nxt_cnt     = 3'd0;
                        nxt_grp_sym = {sh_ff[3:0], rxb};
                        if ({sh_ff[3:0], rxb} == SYM_T) begin
                            nxt_st = RX_RWAIT;
                        end else if ({sh_ff[3:0], rxb} == SYM_IDLE
                                     || st_ff == RX_RWAIT) begin
                            nxt_st     = RX_HUNT;
                            nxt_rx_act = 1'b0;
                        end else begin
                            nxt_grp = 1'b1;
                        end
                    end
                end
            endcase
        end else if (!speed_100) begin
            nxt_st     = RX_HUNT;
            nxt_rx_act = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_ff      <= '0;
            cnt_ff     <= '0;
            st_ff      <= RX_HUNT;
            grp_ff     <= 1'b0;
            pre_ff     <= 1'b0;
            grp_sym_ff <= '0;
            rx_act_ff  <= 1'b0;
        end else begin
            sh_ff      <= nxt_sh;
            cnt_ff     <= nxt_cnt;
            st_ff      <= nxt_st;
            grp_ff     <= nxt_grp;
            pre_ff     <= nxt_pre;
            grp_sym_ff <= nxt_grp_sym;
            rx_act_ff  <= nxt_rx_act;
        end
    end

    // 10M receive: each bit cell is two half-cell samples
    logic       half_ff, nxt_half;
    logic       first_ff, nxt_first;
    logic [3:0] mn_ff, nxt_mn;
    logic [1:0] mc_ff, nxt_mc;
    logic       mvld, nxt_mvld;
    logic       merr, nxt_merr;
    logic       m_act_ff, nxt_m_act;

    always_comb begin
        nxt_half  = half_ff;
        nxt_first = first_ff;
        nxt_mn    = mn_ff;
        nxt_mc    = mc_ff;
        nxt_mvld  = 1'b0;
        nxt_merr  = 1'b0;
        nxt_m_act = m_act_ff;
        if (speed_100 || !rxe) begin
            nxt_half  = 1'b0;
            nxt_mc    = 2'd0;
            nxt_m_act = 1'b0;
        end else begin
            nxt_m_act = 1'b1;
            nxt_half  = ~half_ff;
            if (!half_ff) begin
                nxt_first = rxb;
            end else begin
                nxt_merr = (first_ff == rxb); // No mid-cell transition
                nxt_mn   = {rxb, mn_ff[3:1]};
                nxt_mc   = mc_ff + 2'd1;
                nxt_mvld = (mc_ff == 2'd3);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            half_ff  <= 1'b0;
            first_ff <= 1'b0;
            mn_ff    <= '0;
            mc_ff    <= '0;
            mvld     <= 1'b0;
            merr     <= 1'b0;
            m_act_ff <= 1'b0;
        end else begin
            half_ff  <= nxt_half;
            first_ff <= nxt_first;
            mn_ff    <= nxt_mn;
            mc_ff    <= nxt_mc;
            mvld     <= nxt_mvld;
            merr     <= nxt_merr;
            m_act_ff <= nxt_m_act;
        end
    end

    // Nibble output; lookup output lags grp_ff by one cycle
    logic grp_d_ff;
    nib_t nxt_nib;
    always_comb begin
        nxt_nib = '{valid: 1'b0, err: 1'b0, data: NIB_ZERO};
        if (pre_ff || pend_ff) begin
            nxt_nib = '{valid: 1'b1, err: 1'b0, data: NIB_PREAMBLE};
        end else if (grp_d_ff) begin
            nxt_nib = '{valid: 1'b1, err: dec.invalid, data: dec.nib};
        end else if (mvld) begin
            nxt_nib = '{valid: 1'b1, err: merr, data: nxt_mn};
        end
        nxt_pend = pre_ff;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grp_d_ff  <= 1'b0;
            pend_ff   <= 1'b0;
            rx_nib_ff <= '0;
        end else begin
            grp_d_ff  <= grp_ff;
            pend_ff   <= nxt_pend;
            rx_nib_ff <= nxt_nib;
        end
    end

    // 10M transmit: LSB first, two half cells per bit, bit n as ~b then b
    logic [3:0] tq_ff, nxt_tq;
    logic [2:0] tc_ff, nxt_tc;
    logic       nxt_man, nxt_req;
    always_comb begin
        nxt_tq  = tq_ff;
        nxt_tc  = tc_ff;
        nxt_man = 1'b0;
        nxt_req = 1'b0;
        if (!speed_100 && tx_en) begin
            if (tc_ff == 3'd0) begin
                nxt_tq = tx_nib;
            end
            nxt_man = (tc_ff[0]) ? tq_ff[0] : ~((tc_ff == 3'd0) ? tx_nib[0] : tq_ff[0]);
            if (tc_ff[0]) begin
                nxt_tq = {1'b0, tq_ff[3:1]};
            end
            nxt_tc  = tc_ff + 3'd1;
            nxt_req = (tc_ff == 3'd7);
        end else begin
            nxt_tc = 3'd0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tq_ff         <= '0;
            tc_ff         <= '0;
            man_tx_ff     <= 1'b0;
            tx_bit_req_ff <= 1'b0;
        end else begin
            tq_ff         <= nxt_tq;
            tc_ff         <= nxt_tc;
            man_tx_ff     <= nxt_man;
            tx_bit_req_ff <= nxt_req;
        end
    end

    // Link resolution, carrier sense and collision
    an_state_t  an_ff, nxt_an;
    logic [3:0] common, pick, nxt_mode;
    logic       fd, rx_on;
    assign common = local_abil & partner_abil;
    always_comb begin
        pick = ABIL_NONE;
        for (int i = 0; i < ABIL_W; i++) begin
            if (common[i]) begin
                pick = 4'(1 << i);
            end
        end
    end

    always_comb begin
        nxt_an   = an_ff;
        nxt_mode = link_mode_ff;
        unique case (an_ff)
            AN_IDLE: begin
                if (!an_enable || (!pg && (s100 || s10))) begin
                    // Half duplex only, and only if we support it at that speed
                    nxt_mode = s100 ? (local_abil & 4'b0100) : (local_abil & 4'b0001);
                    if (nxt_mode != ABIL_NONE) begin
                        nxt_an = AN_UP;
                    end
                end else if (pg) begin
                    nxt_an = AN_ACKW;
                end
            end
            AN_ACKW: begin
                if (pa && pick != ABIL_NONE) begin
                    nxt_mode = pick;
                    nxt_an   = AN_UP;
                end else if (!pg) begin
                    nxt_an = AN_IDLE;
                end
            end
            AN_UP: begin
                if (!s100 && !s10) begin
                    nxt_an   = AN_IDLE;
                    nxt_mode = ABIL_NONE;
                end
            end
            default: nxt_an = AN_IDLE;
        endcase
    end

    assign fd    = link_mode_ff[ABIL_100FD] | link_mode_ff[ABIL_10FD];
    assign rx_on = rx_act_ff | m_act_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            an_ff        <= AN_IDLE;
            link_mode_ff <= ABIL_NONE;
            link_up_ff   <= 1'b0;
            an_ack_ff    <= 1'b0;
            adv_abil_ff  <= ABIL_NONE;
            crs_ff       <= 1'b0;
            col_ff       <= 1'b0;
        end else begin
            an_ff        <= nxt_an;
            link_mode_ff <= nxt_mode;
            link_up_ff   <= (nxt_an == AN_UP);
            an_ack_ff    <= (an_ff == AN_ACKW) && pg;
            adv_abil_ff  <= local_abil;
            crs_ff       <= fd ? rx_on : (rx_on | tx_en);
            col_ff       <= !fd && rx_on && tx_en;
        end
    end

    a_col_fd_never: assert property (@(posedge clk) disable iff (!rst_b)
        fd |=> !col_ff) else $error("collision in full duplex");
    a_col_hd_both: assert property (@(posedge clk) disable iff (!rst_b)
        (!fd && rx_on && tx_en) |=> col_ff) else $error("missed collision");
    a_crs_fd_tx: assert property (@(posedge clk) disable iff (!rst_b)
        (fd && !rx_on) |=> !crs_ff) else $error("crs on tx only, fd");
    a_crs_hd_tx: assert property (@(posedge clk) disable iff (!rst_b)
        (!fd && tx_en) |=> crs_ff) else $error("crs missing on tx");
    a_pre_two: assert property (@(posedge clk) disable iff (!rst_b)
        pre_ff |=> rx_nib_ff.valid && rx_nib_ff.data == NIB_PREAMBLE
        ##1 rx_nib_ff.valid && rx_nib_ff.data == NIB_PREAMBLE)
        else $error("preamble pair wrong");
    a_jk_align: assert property (@(posedge clk) disable iff (!rst_b)
        (st_ff == RX_HUNT) |=> !grp_ff) else $error("group before J/K");
    a_lut_data: assert property (@(posedge clk) disable iff (!rst_b)
        (grp_sym_ff == 5'h09) |=> (dec.nib == 4'h1 && !dec.invalid))
        else $error("lookup wrong");
    a_lut_bad: assert property (@(posedge clk) disable iff (!rst_b)
        (grp_sym_ff == 5'h00) |=> dec.invalid) else $error("invalid not flagged");
    a_tr_strip: assert property (@(posedge clk) disable iff (!rst_b)
        (st_ff == RX_RWAIT) |=> !grp_ff) else $error("T/R passed");
    a_an_onehot: assert property (@(posedge clk) disable iff (!rst_b)
        link_up_ff |-> $onehot(link_mode_ff)) else $error("mode not single");
    a_10m_req: assert property (@(posedge clk) disable iff (!rst_b)
        (!speed_100 && tx_en && tc_ff == 3'd7) |=> tx_bit_req_ff)
        else $error("nibble request late");

    c_frame: cover property (@(posedge clk) pre_ff);
    c_col: cover property (@(posedge clk) col_ff);
    c_an_up: cover property (@(posedge clk) an_ff == AN_ACKW ##1 an_ff == AN_UP);
    c_man_nib: cover property (@(posedge clk) mvld);
endmodule
`default_nettype wire

// ### test/line_partner.sv
// Line-side and link-partner model feeding the codec core
`timescale 1ns/1ps
`default_nettype none
module line_partner (
    input  wire logic       clk,
    input  wire logic       an_ack,
    output var  logic       rx_bit,
    output var  logic       rx_bit_en,
    output var  logic       sig_100,
    output var  logic       sig_10,
    output var  logic       partner_page,
    output var  logic       partner_ack,
    output var  logic [3:0] partner_abil
);
    localparam time DLY = 1ns;

    logic [1:0] q[$];

    initial begin
        rx_bit = 1'b0;
        quiet();
    end

    // One sample per cycle; an empty queue releases the line
    always @(posedge clk) begin
        #DLY;
        if (q.size() > 0) begin
            {rx_bit_en, rx_bit} = q.pop_front();
        end else begin
            rx_bit_en = 1'b0;
            rx_bit = ~rx_bit;  // No stale level once released
        end
    end

    task automatic quiet();
        q.delete();
        sig_100 = 1'b0;
        sig_10 = 1'b0;
        partner_page = 1'b0;
        partner_ack = 1'b0;
        partner_abil = 4'h0;
    endtask

    task automatic sym(input logic [4:0] s);
        for (int i = 4; i >= 0; i--) begin
            q.push_back({1'b1, s[i]});
        end
    endtask

    task automatic drain();
        while (q.size() > 0) begin
            @(posedge clk);
        end
    endtask

    task automatic offer(input logic [3:0] abil);
        partner_abil = abil;
        partner_page = 1'b1;
        sig_10 = 1'b1;
    endtask

    // Acknowledge once our own page has been acknowledged, or after 20 cycles without it
    task automatic confirm();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (an_ack !== 1'b1 && k < 20);
        #DLY;
        partner_ack = 1'b1;
    endtask

    // A partner that does not negotiate only shows its line signal
    task automatic plain(input logic s100, input logic s10);
        sig_100 = s100;
        sig_10 = s10;
    endtask
endmodule
`default_nettype wire

// ### test/phy_symbol_decode_crs_col_bench.sv
// Self-checking bench for the symbol codec core
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(8'(g), 8'(e))
module phy_symbol_decode_crs_col_bench;
    import phy_codec_pkg::*;
    localparam time DLY = 1ns;
    localparam logic [4:0] CODE [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
        5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

    logic       clk = 1'b0;
    logic       rst_b;
    logic       tx_en;
    logic [3:0] tx_nib;
    logic       speed_100;
    logic       an_enable;
    logic [3:0] local_abil;
    logic       rx_bit;
    logic       rx_bit_en;
    logic       sig_100;
    logic       sig_10;
    logic       partner_page;
    logic       partner_ack;
    logic [3:0] partner_abil;
    nib_t       rx_nib_ff;
    logic       crs_ff;
    logic       col_ff;
    logic       man_tx_ff;
    logic       tx_bit_req_ff;
    logic       an_ack_ff;
    logic [3:0] adv_abil_ff;
    logic       link_up_ff;
    logic [3:0] link_mode_ff;
    int         fails = 0;
    int         compares = 0;
    nib_t       got[$];

    phy_symbol_decode_crs_col phy_symbol_decode_crs_col_inst (
        .clk(clk), .rst_b(rst_b), .rx_bit(rx_bit), .rx_bit_en(rx_bit_en),
        .tx_en(tx_en), .tx_nib(tx_nib), .speed_100(speed_100), .an_enable(an_enable),
        .local_abil(local_abil), .partner_abil(partner_abil), .partner_page(partner_page),
        .partner_ack(partner_ack), .sig_100(sig_100), .sig_10(sig_10),
        .rx_nib_ff(rx_nib_ff), .crs_ff(crs_ff), .col_ff(col_ff), .man_tx_ff(man_tx_ff),
        .tx_bit_req_ff(tx_bit_req_ff), .an_ack_ff(an_ack_ff), .adv_abil_ff(adv_abil_ff),
        .link_up_ff(link_up_ff), .link_mode_ff(link_mode_ff)
    );

    line_partner line_partner_inst (
        .clk(clk), .an_ack(an_ack_ff), .rx_bit(rx_bit), .rx_bit_en(rx_bit_en),
        .sig_100(sig_100), .sig_10(sig_10), .partner_page(partner_page),
        .partner_ack(partner_ack), .partner_abil(partner_abil)
    );

    always #20 clk = ~clk;

    // Nibble valid is a one-cycle pulse, so capture every edge
    always @(posedge clk) begin
        if (rx_nib_ff.valid === 1'b1) begin
            got.push_back(rx_nib_ff);
        end
    end

    task automatic check_val(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #DLY;
    endtask

    task automatic do_reset();
        rst_b = 1'b0;
        tx_en = 1'b0;
        tx_nib = 4'h0;
        speed_100 = 1'b0;
        an_enable = 1'b0;
        local_abil = 4'h0;
        line_partner_inst.quiet();
        cyc(6);
        rst_b = 1'b1;
        got.delete();
    endtask

    task automatic t_rx100();
        do_reset();
        speed_100 = 1'b1;
        line_partner_inst.sym(SYM_IDLE);
        line_partner_inst.q.push_back(2'b11);  // Stray bits, off the group boundary
        line_partner_inst.q.push_back(2'b10);
        line_partner_inst.sym(SYM_J);
        line_partner_inst.sym(SYM_K);
        for (int i = 0; i < 16; i++) begin
            line_partner_inst.sym(CODE[i]);
        end
        line_partner_inst.sym(5'h00);
        line_partner_inst.sym(SYM_T);
        line_partner_inst.sym(SYM_R);
        line_partner_inst.sym(SYM_IDLE);
        line_partner_inst.drain();
        cyc(8);
        `CHK(got.size(), 19);
        `CHK(got[0], {2'b10, NIB_PREAMBLE});
        `CHK(got[1], {2'b10, NIB_PREAMBLE});
        for (int i = 0; i < 16; i++) begin
            `CHK(got[i + 2], {2'b10, i[3:0]});
        end
        `CHK(got[18].err, 1'b1);
    endtask

    // Bit value sits in the second half-cell; bad drops the last transition
    task automatic man_nib(input logic [3:0] n, input logic bad);
        for (int i = 0; i < 4; i++) begin
            line_partner_inst.q.push_back({1'b1, ~n[i] ^ (bad && i == 3)});
            line_partner_inst.q.push_back({1'b1, n[i]});
        end
    endtask

    task automatic t_rx10();
        do_reset();
        man_nib(4'hB, 1'b0);
        man_nib(4'h6, 1'b1);
        line_partner_inst.drain();
        cyc(8);
        `CHK(got.size(), 2);
        `CHK(got[0], {2'b10, 4'hB});
        `CHK(got[1], {2'b11, 4'h6});
    endtask

    task automatic t_tx10();
        logic [7:0] sr;
        logic [7:0] exp [2];
        int         k;
        exp = '{8'h69, 8'hA6};
        do_reset();
        sr = 8'h00;
        tx_nib = 4'h9;
        tx_en = 1'b1;
        for (int n = 0; n < 2; n++) begin
            k = 0;
            do begin
                cyc(1);
                sr = {sr[6:0], man_tx_ff};
                k++;
            end while (tx_bit_req_ff !== 1'b1 && k < 20);
            `CHK(sr, exp[n]);
            tx_nib = 4'h4;
        end
        `CHK(crs_ff, 1'b1);
        tx_en = 1'b0;
    endtask

    // Link-up is waited for with a bound; a missing link shows in the compare
    task automatic wait_link();
        for (int k = 0; k < 20 && link_up_ff !== 1'b1; k++) begin
            @(posedge clk);
        end
        cyc(2);
    endtask

    task automatic t_neg(input logic [3:0] loc, input logic [3:0] par, input logic [3:0] exp);
        do_reset();
        an_enable = 1'b1;
        local_abil = loc;
        line_partner_inst.offer(par);
        line_partner_inst.confirm();
        `CHK(an_ack_ff, 1'b1);
        `CHK(adv_abil_ff, loc);
        wait_link();
        `CHK(link_mode_ff, exp);
        `CHK(link_up_ff, exp != 4'h0);
    endtask

    task automatic t_pd(input logic an, input logic [3:0] loc, input logic s100,
                        input logic s10, input logic [3:0] exp);
        do_reset();
        an_enable = an;
        local_abil = loc;
        line_partner_inst.plain(s100, s10);
        wait_link();
        `CHK(link_mode_ff, exp);
    endtask

    task automatic t_dup(input logic fd);
        t_neg(4'hF, {2'b00, fd, ~fd}, {2'b00, fd, ~fd});
        tx_en = 1'b1;
        cyc(5);
        `CHK(crs_ff, !fd);
        `CHK(col_ff, 1'b0);
        for (int i = 0; i < 40; i++) begin
            line_partner_inst.q.push_back({1'b1, i[0]});
        end
        cyc(6);
        `CHK(crs_ff, 1'b1);
        `CHK(col_ff, !fd);
        tx_en = 1'b0;
        line_partner_inst.drain();
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Whole run is under a thousand cycles; this span leaves ample margin
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end

    initial begin
        do_reset();
        `CHK(link_mode_ff, 4'h0);
        t_rx100();
        t_rx10();
        t_tx10();
        t_neg(4'hF, 4'h3, 4'h2);
        t_neg(4'hF, 4'h5, 4'h4);
        t_neg(4'hF, 4'hF, 4'h8);
        t_neg(4'hA, 4'h7, 4'h2);
        t_neg(4'h8, 4'h3, 4'h0);
        t_pd(1'b1, 4'hF, 1'b1, 1'b0, 4'h4);
        t_pd(1'b0, 4'hF, 1'b0, 1'b1, 4'h1);
        t_pd(1'b1, 4'hB, 1'b1, 1'b0, 4'h0);
        t_dup(1'b0);
        t_dup(1'b1);
        conclude();
    end
endmodule
`default_nettype wire
